//--- ard_regs.svh
// constants of the acceleration/deceleration ramp generator
`ifndef ARD_REGS_SVH
`define ARD_REGS_SVH
// frequencies in 0.01 Hz, times in 10 ms units
`define ARD_REF_DEF    16'h1388
`define ARD_REF_MIN    16'h0064
`define ARD_REF_MAX    16'h9c40
`define ARD_BASE_DEF   16'h1388
`define ARD_BASE_MIN   16'h0001
`define ARD_TIME_MAX   20'h57e40
`define ARD_TIME_SAME  20'hf41dc
`define ARD_TIME_SMALL 20'h001f4
`define ARD_TIME_LARGE 20'h003e8
`define ARD_TIME_FLOOR 20'h00003
`define ARD_TIME_MIN   20'h00004
`define ARD_PAT_LINEAR 2'h0
`define ARD_PAT_SA     2'h1
`define ARD_FRAC       16
`define ARD_S_NUM      4'h9
`define ARD_S_SHIFT    3
`define ARD_TICK_NS    10000000
`define ARD_CLK_NS     10
`endif

//--- ard_pkg.sv
// types of the acceleration/deceleration ramp generator
package ard_pkg;
  typedef struct packed {
    logic [19:0] accel_time;
    logic [19:0] decel_time;
    logic [19:0] accel2_time;
    logic [19:0] decel2_time;
    logic [15:0] ref_freq;
    logic [15:0] base_freq;
    logic [1:0]  pattern;
  } ard_cfg_s;
  typedef struct packed {
    logic accelerating;
    logic decelerating;
    logic at_target;
  } ard_status_s;
  typedef enum logic [0:0] {ST_IDLE, ST_DIV} ard_state_e;
endpackage : ard_pkg

//--- ard_serial_div.sv
// restoring serial divider, one quotient bit per clock
`timescale 1ns/100ps
module ard_serial_div #(
  parameter int NW = 56,
  parameter int DW = 40
) (
  input  wire logic          sys_clk_in,
  input  wire logic          arst_n_in,
  input  wire logic          start_in,
  input  wire logic [NW-1:0] num_in,
  input  wire logic [DW-1:0] den_in,
  output logic      [NW-1:0] quot_out,
  output logic               done_out
);
  localparam int CW = $clog2(NW + 1);
  logic [DW-1:0] den_reg;
  logic [DW:0]   rem_reg;
  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  wire  [DW:0]   rem_sh_w  = {rem_reg[DW-1:0], quot_out[NW-1]};
  wire           fits_w    = rem_sh_w >= {1'b0, den_reg};
  wire  [DW:0]   rem_next  = fits_w ? rem_sh_w - {1'b0, den_reg} : rem_sh_w;
  wire           last_w    = cnt_reg == CW'(1);

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      den_reg  <= '0;
      rem_reg  <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      quot_out <= '0;
      done_out <= 1'b0;
    end else if (start_in) begin
      den_reg  <= den_in;
      rem_reg  <= '0;
      cnt_reg  <= CW'(NW);
      busy_reg <= 1'b1;
      quot_out <= num_in;
      done_out <= 1'b0;
    end else begin
      done_out <= busy_reg && last_w;
      if (busy_reg) begin
        rem_reg  <= rem_next;
        quot_out <= {quot_out[NW-2:0], fits_w};
        cnt_reg  <= cnt_reg - CW'(1);
        busy_reg <= !last_w;
      end
    end
  end
endmodule : ard_serial_div

//--- ard_ramp_gen.sv
// output-frequency ramp generator with two time sets and s-pattern a
`timescale 1ns/100ps
`include "ard_regs.svh"
// Operation
// - rising slope equals reference frequency over acceleration time.
// - falling slope equals reference frequency over deceleration time.
// - reference frequency 1 to 400 Hz, 50 Hz after reset.
// - primary ramp times accept zero to 3600 seconds.
// - primary times and second accel default 5 s, large size 10 s.
// - second-set select picks the second acceleration and deceleration times.
// - second decel 0 to 3600 s; code 9999 reuses second accel time.
// - s-pattern a times count to base frequency, not reference.
// - s-pattern a above base: t = 4/9 T f^2/fb^2 + 5/9 T.
// - any ramp time at or below 30 ms acts as 40 ms.
// - pattern zero gives constant slope on both ramps.
module ard_ramp_gen #(
  parameter bit LARGE_SIZE  = 1'b0,
  parameter int TICK_CYCLES = `ARD_TICK_NS / `ARD_CLK_NS
) (
  input  wire logic                sys_clk_in,
  input  wire logic                arst_n_in,
  input  wire ard_pkg::ard_cfg_s   cfg_in,
  input  wire logic                cfg_load_in,
  input  wire logic                second_set_select_in,
  input  wire logic [15:0]         target_freq_in,
  output logic      [15:0]         out_freq_out,
  output ard_pkg::ard_status_s     status_out
);
  localparam int NW = 56;
  localparam int DW = 40;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [19:0] TIME_DEF =
    LARGE_SIZE ? `ARD_TIME_LARGE : `ARD_TIME_SMALL;

  // time slots: 0 accel, 1 decel, 2 second accel, 3 second decel
  logic [19:0]          t_reg [4];
  logic [19:0]          t_in_w [4];
  logic [19:0]          t_clip_w [4];
  logic [15:0]          ref_reg;
  logic [15:0]          base_reg;
  logic [1:0]           pat_reg;
  logic [31:0]          freq_reg;
  logic [31:0]          freq_next;
  logic [TW-1:0]        tick_reg;
  logic                 up_reg;
  logic                 div_start_reg;
  ard_pkg::ard_state_e  state_reg;
  logic [NW-1:0]        quot_w;
  logic                 div_done_w;

  assign t_in_w[0] = cfg_in.accel_time;
  assign t_in_w[1] = cfg_in.decel_time;
  assign t_in_w[2] = cfg_in.accel2_time;
  assign t_in_w[3] = cfg_in.decel2_time;

  // out-of-range times saturate; the same-as-accel code passes untouched
  for (genvar i = 0; i < 4; i++) begin : g_clip
    assign t_clip_w[i] =
      (i == 3 && t_in_w[i] == `ARD_TIME_SAME) ? t_in_w[i] :
      (t_in_w[i] > `ARD_TIME_MAX) ? `ARD_TIME_MAX : t_in_w[i];
  end

  wire [15:0] ref_clip_w =
    cfg_in.ref_freq < `ARD_REF_MIN ? `ARD_REF_MIN :
    cfg_in.ref_freq > `ARD_REF_MAX ? `ARD_REF_MAX : cfg_in.ref_freq;
  wire [15:0] base_clip_w =
    cfg_in.base_freq < `ARD_BASE_MIN ? `ARD_BASE_MIN : cfg_in.base_freq;

  // active time set
  wire [19:0] acc_raw_w = second_set_select_in ? t_reg[2] : t_reg[0];
  wire [19:0] dec_raw_w = !second_set_select_in ? t_reg[1] :
    (t_reg[3] == `ARD_TIME_SAME ? t_reg[2] : t_reg[3]);
  wire [19:0] raw_w     = up_reg ? acc_raw_w : dec_raw_w;
  wire [19:0] t_eff_w   =
    raw_w <= `ARD_TIME_FLOOR ? `ARD_TIME_MIN : raw_w;

  // slope source: reference, or base frequency in s-pattern a
  wire        pat_sa_w  = pat_reg == `ARD_PAT_SA;
  wire [15:0] f_now_w   = freq_reg[31:16];
  wire        above_w   = pat_sa_w && f_now_w >= base_reg;
  wire [15:0] scale_w   = pat_sa_w ? base_reg : ref_reg;
  wire [31:0] fb_sq_w   = base_reg * base_reg;
  wire [35:0] t_f_w     = t_eff_w * f_now_w;
  // 36 bits: nine times a large base squared would wrap in 32
  wire [35:0] s_num_w   = `ARD_S_NUM * fb_sq_w;
  // above base: df/dt = 9 fb^2 / (8 T f), the slope of the s curve
  wire [NW-1:0] num_w   = above_w ?
    NW'({s_num_w, {`ARD_FRAC{1'b0}}}) :
    NW'({scale_w, {`ARD_FRAC{1'b0}}});
  wire [DW-1:0] den_w   = above_w ?
    DW'({t_f_w, {`ARD_S_SHIFT{1'b0}}}) : DW'(t_eff_w);

  wire [31:0] tgt_w     = {target_freq_in, {`ARD_FRAC{1'b0}}};
  wire [31:0] step_w    = quot_w[31:0];
  wire [32:0] sum_w     = {1'b0, freq_reg} + {1'b0, step_w};
  wire [31:0] gap_w     = up_reg ? tgt_w - freq_reg : freq_reg - tgt_w;
  wire        tick_w    = tick_reg == TW'(TICK_CYCLES - 1);
  wire        moving_w  = freq_reg != tgt_w;
  wire        dir_up_w  = tgt_w > freq_reg;
  // command moved behind us during the divide: land on it, never carry on
  wire        passed_w  = up_reg ? freq_reg >= tgt_w : freq_reg <= tgt_w;

  // clamp to the command so a step never carries past it
  always_comb begin
    freq_next = freq_reg;
    if (state_reg == ard_pkg::ST_DIV && div_done_w) begin
      if (passed_w || gap_w <= step_w || (up_reg && sum_w[32]))
        freq_next = tgt_w;
      else if (up_reg)
        freq_next = sum_w[31:0];
      else
        freq_next = freq_reg - step_w;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      t_reg[0] <= TIME_DEF;
      t_reg[1] <= TIME_DEF;
      t_reg[2] <= TIME_DEF;
      t_reg[3] <= `ARD_TIME_SAME;
      ref_reg  <= `ARD_REF_DEF;
      base_reg <= `ARD_BASE_DEF;
      pat_reg  <= `ARD_PAT_LINEAR;
    end else if (cfg_load_in) begin
      t_reg    <= t_clip_w;
      ref_reg  <= ref_clip_w;
      base_reg <= base_clip_w;
      pat_reg  <= cfg_in.pattern;
    end
  end

  // a target change mid-division clamps the pending step when the division completes; direction follows at the next tick
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_reg      <= '0;
      state_reg     <= ard_pkg::ST_IDLE;
      up_reg        <= 1'b0;
      div_start_reg <= 1'b0;
      freq_reg      <= '0;
    end else begin
      tick_reg      <= tick_w ? '0 : tick_reg + TW'(1);
      div_start_reg <= 1'b0;
      freq_reg      <= freq_next;
      unique case (state_reg)
        ard_pkg::ST_IDLE: if (tick_w && moving_w) begin
          up_reg        <= dir_up_w;
          div_start_reg <= 1'b1;
          state_reg     <= ard_pkg::ST_DIV;
        end
        ard_pkg::ST_DIV: if (div_done_w) state_reg <= ard_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_freq_out <= '0;
      status_out   <= '0;
    end else begin
      out_freq_out            <= freq_next[31:16];
      status_out.accelerating <= freq_next < tgt_w;
      status_out.decelerating <= freq_next > tgt_w;
      status_out.at_target    <= freq_next == tgt_w;
    end
  end

  ard_serial_div #(.NW(NW), .DW(DW)) u_div (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .start_in   (div_start_reg),
    .num_in     (num_w),
    .den_in     (den_w),
    .quot_out   (quot_w),
    .done_out   (div_done_w)
  );

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_ACC_SLOPE: assert property (
    div_start_reg && up_reg && !pat_sa_w |->
      num_w == NW'({ref_reg, 16'h0000}) && den_w == DW'(t_eff_w))
    else $error("accel slope not ref over accel time");
  AST_DEC_SLOPE: assert property (
    div_start_reg && !up_reg && !pat_sa_w |->
      num_w == NW'({ref_reg, 16'h0000}) && den_w == DW'(t_eff_w))
    else $error("decel slope not ref over decel time");
  AST_REF_RANGE: assert property (
    ref_reg >= 16'h0064 && ref_reg <= 16'h9c40)
    else $error("reference frequency out of range");
  AST_REF_DEFAULT: assert property (
    $rose(arst_n_in) |-> ref_reg == 16'h1388)
    else $error("reference frequency not 50 Hz after reset");
  AST_TIME_RANGE: assert property (
    t_reg[0] <= 20'h57e40 && t_reg[1] <= 20'h57e40)
    else $error("primary ramp time above 3600 s");
  AST_TIME_DEFAULT: assert property (
    $past(!arst_n_in) |-> t_reg[0] == TIME_DEF && t_reg[2] == TIME_DEF)
    else $error("ramp time default wrong");
  AST_SET_SELECT: assert property (
    second_set_select_in && up_reg |-> raw_w == t_reg[2])
    else $error("second set not used while selected");
  AST_SAME_CODE: assert property (
    second_set_select_in && !up_reg && t_reg[3] == 20'hf41dc
      |-> raw_w == t_reg[2])
    else $error("second decel code did not reuse second accel");
  AST_BASE_SCALE: assert property (
    div_start_reg && pat_sa_w && !above_w |->
      num_w == NW'({base_reg, 16'h0000}))
    else $error("s-pattern a not scaled to base frequency");
  AST_S_CURVE: assert property (
    div_start_reg && above_w |->
      den_w == DW'({36'(t_eff_w) * 36'(f_now_w), 3'b000}))
    else $error("s-pattern a denominator wrong");
  AST_MIN_TIME: assert property (
    raw_w <= 20'h00003 |-> t_eff_w == 20'h00004)
    else $error("short ramp time not raised to 40 ms");
  AST_NO_OVERSHOOT: assert property (
    div_done_w && state_reg == ard_pkg::ST_DIV && up_reg |=>
      freq_reg <= $past(tgt_w))
    else $error("output frequency overshot command");
  AST_STEP_DONE: assert property (
    div_start_reg |-> ##[56:58] state_reg == ard_pkg::ST_IDLE)
    else $error("step not applied within division time");

  COV_ACCEL_DONE: cover property (
    status_out.accelerating ##1 status_out.at_target);
  COV_DECEL_DONE: cover property (
    status_out.decelerating ##1 status_out.at_target);
  COV_SECOND_SET: cover property (
    div_start_reg && second_set_select_in && !up_reg);
  COV_S_HIGH: cover property (div_start_reg && above_w);
endmodule : ard_ramp_gen

//--- ard_motor_stage.sv
// motor power stage model counting the frequency updates it receives
`timescale 1ns/100ps
module ard_motor_stage (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [15:0] drive_freq_in,
  input  wire logic        clear_in,
  output logic      [15:0] step_count_out
);
  logic [15:0] last_reg;
  logic [15:0] cnt_reg;
  wire         changed = (drive_freq_in != last_reg);
  // combinational add so the count is current in the update cycle
  assign step_count_out = cnt_reg + {15'h0000, changed};
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_reg <= 16'h0000;
      cnt_reg  <= 16'h0000;
    end else begin
      last_reg <= drive_freq_in;
      cnt_reg  <= clear_in ? 16'h0000 : step_count_out;
    end
  end
endmodule : ard_motor_stage

//--- tb_accel_decel_ramp_timing.sv
// self-checking bench of the ramp generator
`timescale 1ns/100ps
`include "ard_regs.svh"
module tb_accel_decel_ramp_timing;
  localparam int TICK = 100;
  typedef struct {int target; int ticks; bit up;} ard_note_s;
  logic              sys_clk_in;
  logic              arst_n_in;
  logic              cfg_load_in;
  logic              second_set_select_in;
  logic              clear;
  logic              prev_at;
  logic [15:0]       target_freq_in;
  logic [15:0]       out_freq_out;
  logic [15:0]       step_count;
  logic [2:0]        dir_exp;
  logic [31:0]       rnd = 32'h00000050;
  ard_pkg::ard_cfg_s cfg_in;
  ard_pkg::ard_cfg_s cfg_m;
  ard_pkg::ard_status_s status_out;
  ard_note_s         notes[$];
  int                errors = 0;
  int                num_checks = 0;
  int                cur = 0;

  ard_ramp_gen #(.LARGE_SIZE(1'b0), .TICK_CYCLES(TICK)) DUT (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .cfg_in(cfg_in),
    .cfg_load_in(cfg_load_in), .second_set_select_in(second_set_select_in),
    .target_freq_in(target_freq_in), .out_freq_out(out_freq_out),
    .status_out(status_out));
  ard_motor_stage MOTOR (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .drive_freq_in(out_freq_out), .clear_in(clear),
    .step_count_out(step_count));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic cmp16(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h got %h", what, exp, got);
    end
  endtask : cmp16

  task automatic cmp_st(string what, logic [2:0] exp, logic [2:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %b got %b", what, exp, got);
    end
  endtask : cmp_st

  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs

  function automatic int eff_t(bit up, bit sel);
    int t;
    if (up) t = sel ? cfg_m.accel2_time : cfg_m.accel_time;
    else if (!sel) t = cfg_m.decel_time;
    else if (cfg_m.decel2_time == `ARD_TIME_SAME) t = cfg_m.accel2_time;
    else t = cfg_m.decel2_time;
    if (t <= 3) t = 4;
    return t;
  endfunction : eff_t

  // walks the 16.16 ramp tick by tick, as the power stage would see it
  function automatic int model_ticks(int from, int to, bit sel);
    longint f, tg, st, fb;
    int n, t;
    t = eff_t(to > from, sel);
    fb = cfg_m.base_freq;
    f = longint'(from) << 16;
    tg = longint'(to) << 16;
    n = 0;
    while (f != tg) begin
      if (cfg_m.pattern == 2'h1 && (f >> 16) >= fb)
        st = 9 * fb * fb * 65536 / (8 * t * (f >> 16));
      else if (cfg_m.pattern == 2'h1) st = fb * 65536 / t;
      else st = longint'(cfg_m.ref_freq) * 65536 / t;
      if (f < tg) f = (f + st >= tg) ? tg : f + st;
      else f = (f - tg <= st) ? tg : f - st;
      n++;
    end
    return n;
  endfunction : model_ticks

  task automatic load(ard_pkg::ard_cfg_s c);
    cfg_m = c;
    @(posedge sys_clk_in);
    cfg_in <= c;
    cfg_load_in <= 1'b1;
    @(posedge sys_clk_in);
    cfg_load_in <= 1'b0;
  endtask : load

  task automatic ramp(int tgt, bit sel);
    ard_note_s nt;
    int n;
    nt.target = tgt;
    nt.up = tgt > cur;
    nt.ticks = model_ticks(cur, tgt, sel);
    @(posedge sys_clk_in);
    target_freq_in <= tgt[15:0];
    second_set_select_in <= sel;
    clear <= 1'b1;
    @(posedge sys_clk_in);
    clear <= 1'b0;
    // note only once status follows the new command, not the old one
    notes.push_back(nt);
    n = 0;
    while (notes.size() > 0 && n < 200 * TICK) begin
      @(posedge sys_clk_in);
      n++;
    end
    cur = tgt;
    if (notes.size() > 0) begin
      errors++;
      wrap_up();
    end
  endtask : ramp

  always @(negedge sys_clk_in) begin
    if (arst_n_in && notes.size() > 0) begin
      if (prev_at && !status_out.at_target) begin
        dir_exp = {notes[0].up, !notes[0].up, 1'b0};
        cmp_st("direction", dir_exp, status_out);
      end
      if (!prev_at && status_out.at_target) begin
        cmp16("final freq", notes[0].target[15:0], out_freq_out);
        cmp16("tick count", notes[0].ticks[15:0], step_count);
        cmp_st("status", 3'h1, status_out);
        void'(notes.pop_front());
      end
    end
    prev_at = status_out.at_target;
  end

  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial begin
    arst_n_in = 1'b0;
    cfg_in = '0;
    cfg_load_in = 1'b0;
    second_set_select_in = 1'b0;
    clear = 1'b0;
    target_freq_in = 16'h0000;
    prev_at = 1'b1;
    cfg_m = '{`ARD_TIME_SMALL, `ARD_TIME_SMALL, `ARD_TIME_SMALL,
              `ARD_TIME_SAME, `ARD_REF_DEF, `ARD_BASE_DEF, `ARD_PAT_LINEAR};
    repeat (2) @(posedge sys_clk_in);
    cmp16("reset freq", 16'h0000, out_freq_out);
    arst_n_in <= 1'b1;
    ramp(1000, 1'b0);
    ramp(0, 1'b0);
    ramp(1000, 1'b1);
    ramp(0, 1'b1);
    load('{20'h00028, 20'h00050, 20'h00014, 20'h0001e, 16'h0fa0, 16'h1388,
           2'h0}); // 40 Hz in 0.4 s up, 0.8 s down
    ramp(int'(xs() & 32'h000003ff) + 100, 1'b0);
    ramp(0, 1'b1);
    load('{20'h00003, 20'h00000, 20'h00014, 20'hf41dc, 16'h0190, 16'h1388,
           2'h2});
    ramp(1000, 1'b0);
    ramp(0, 1'b0);
    load('{20'h0000a, 20'h0000a, 20'h0000a, 20'hf41dc, 16'h1388, 16'h03e8,
           2'h1});
    ramp(3000, 1'b0);
    ramp(0, 1'b0);
    wrap_up();
  end
endmodule : tb_accel_decel_ramp_timing
